// ---- hdl/pac_ctrl.sv ----
/*
  Host-side controller for phase alignment and frame reference generation of
  an RF synthesizer. Software orders it over APB; it drives the synthesizer
  settings, the alignment pin and the frame reference request pin.
  Assumes the synthesizer reference clock is pclk itself at 40 MHz and that
  the settings struct is carried to the device by its own programming port.
*/
// Behaviour
// - Non-critical alignment: toggle mode zero to one.
// - Category three: pin only, reference at most 40MHz.
// - Category four: never attempt alignment.
// - Divide feedback values by included ratio first.
// - Category two may use pin rising edge.
// - Pin edges kept away from reference edges.
// - Pin ignore set unless pin used aligned.
// - Feedback divider at least 45 or 49.
// - Prefer order two or less when ratio above one.
// - Frame reference only after alignment mode set.
// - Delay weights always sum to 63.
// - Frame enable exactly when output B selects it.
`include "pac_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pac_ctrl
  import pac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output var  pac_dev_cfg_t dev_cfg,
  output var  logic        phase_align_pin,
  output var  logic        frame_ref_request
);

  localparam logic [7:0] PULSE_CYC  = 8'(`PAC_PIN_PULSE_CYC);   // Pin pulse width.
  localparam logic [7:0] SETTLE_CYC = 8'(`PAC_SETTLE_CYC);      // Settle time per step.

  pac_st_t q;       // Registered state.
  pac_st_t next_q;  // Next state.
  logic    pin_q;   // Pin retimed onto the falling edge.

  // Decodes a mapped register address.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `PAC_CTRL_ADDR) || (a == `PAC_MUX_ADDR) || (a == `PAC_FEED_ADDR) ||
             (a == `PAC_DELAY_ADDR) || (a == `PAC_STATUS_ADDR) || (a == `PAC_SEED_ADDR);
  endfunction

  // Ratio of the channel divider that moves into feedback.
  function automatic logic [2:0] inc_ratio(input logic [1:0] a, input logic [1:0] b,
                                           input logic [2:0] s1, input logic d2);
    if ((a != `PAC_SEL_OUTPUT_DIVIDER_RATIO) && (b != `PAC_SEL_OUTPUT_DIVIDER_RATIO) && (b != `PAC_SEL_FRAME)) begin
      inc_ratio = 3'h1;
    end else if (d2) begin
      inc_ratio = 3'h4;
    end else begin
      inc_ratio = 3'({s1, 1'b0});
    end
  endfunction

  // Splits a delay word into four weights that always sum to 63.
  function automatic logic [23:0] weights(input logic [7:0] w);
    logic [8:0] x;
    logic [8:0] w1;
    logic [8:0] w2;
    logic [8:0] w3;
    logic [8:0] w4;
    x  = (w > `PAC_DWORD_MAX) ? {1'b0, `PAC_DWORD_MAX} : {1'b0, w};
    w1 = 9'h000;
    w2 = 9'h000;
    w3 = 9'h000;
    w4 = 9'h000;
    if (x < 9'd36) begin
      w1 = 9'd36 - x;
      w2 = 9'd27 + x;
    end else if (x < 9'd99) begin
      w2 = 9'd99 - x;
      w3 = x - 9'd36;
    end else if (x < 9'd162) begin
      w3 = 9'd162 - x;
      w4 = x - 9'd99;
    end else if (x < 9'd225) begin
      w4 = 9'd225 - x;
      w1 = x - 9'd162;
    end else begin
      w1 = 9'd288 - x;
      w2 = x - 9'd225;
    end
    weights = {w1[5:0], w2[5:0], w3[5:0], w4[5:0]};
  endfunction

  logic        wr_acc;  // Write taking effect this cycle.
  logic [2:0]  ratio;   // Current included ratio.
  logic [15:0] nmin;    // Feedback floor for the current order.
  logic [23:0] wts;     // Current delay weights.

  assign wr_acc  = psel && penable && pwrite && mapped(paddr);
  assign ratio   = inc_ratio(q.out_a, q.out_b, q.divider_second_stage, q.div2);
  assign nmin    = (q.order >= 3'h3) ? `PAC_NMIN_O3 : ((q.order == 3'h2) ? `PAC_NMIN_O2 : 16'h0000);
  assign wts     = weights(q.dword);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // Next-state logic: register writes, alignment sequencer, frame request.
  always_comb begin
    next_q = q;
    // Every accepted seed write becomes one load strobe, so steps add up.
    next_q.seed_ld = wr_acc && (paddr == `PAC_SEED_ADDR) && (q.st == PAC_IDLE);
    if (q.cnt != 8'h00) begin
      next_q.cnt = q.cnt - 8'h01;
    end
    // Register writes; configuration changes are refused while a sequence runs.
    if (wr_acc && q.st == PAC_IDLE) begin
      case (paddr)
        `PAC_CTRL_ADDR: begin
          next_q.use_pin     = pwdata[`PAC_CTRL_USE_PIN];
          next_q.cat         = pwdata[`PAC_CTRL_CAT_LSB +: 2];
          next_q.repeat_mode = pwdata[`PAC_CTRL_REPEAT];
          next_q.pulsed      = pwdata[`PAC_CTRL_PULSED];
          next_q.bpc         = pwdata[`PAC_CTRL_BPC_LSB +: 4];
          next_q.pre         = pwdata[`PAC_CTRL_PRE_LSB +: 2];
          next_q.sdiv        = pwdata[`PAC_CTRL_SDIV_LSB +: 11];
        end
        `PAC_MUX_ADDR: begin
          next_q.out_a = pwdata[`PAC_MUX_A_LSB +: 2];
          next_q.out_b = pwdata[`PAC_MUX_B_LSB +: 2];
          next_q.divider_second_stage  = pwdata[`PAC_MUX_DIVIDER_SECOND_STAGE_LSB +: 3];
          next_q.div2  = pwdata[`PAC_MUX_DIV2];
          next_q.order = pwdata[`PAC_MUX_ORDER_LSB +: 3];
        end
        `PAC_FEED_ADDR: begin
          next_q.n_raw   = pwdata[15:0];
          next_q.num_raw = pwdata[31:16];
        end
        `PAC_DELAY_ADDR: begin
          next_q.dword = pwdata[7:0];
        end
        `PAC_SEED_ADDR: begin
          next_q.seed = pwdata[15:0];
        end
        default: begin
          next_q.cnt = next_q.cnt;
        end
      endcase
    end
    // Alignment sequencer.
    case (q.st)
      PAC_IDLE: begin
        if (wr_acc && paddr == `PAC_CTRL_ADDR && pwdata[`PAC_CTRL_ALIGN_GO]) begin
          next_q.ref_cat4   = 1'b0;
          next_q.n_low      = 1'b0;
          next_q.order_warn = 1'b0;
          if (pwdata[`PAC_CTRL_CAT_LSB +: 2] == `PAC_CAT4) begin
            next_q.ref_cat4 = 1'b1;
          end else begin
            next_q.aligned = 1'b0;
            next_q.freq    = 1'b0;
            next_q.mode    = 1'b0;
            next_q.st      = PAC_PROG;
          end
        end
      end
      PAC_PROG: begin
        // Feedback values are scaled down before alignment mode is entered.
        next_q.n_out   = 16'(q.n_raw / {13'h0000, ratio});
        next_q.num_out = 16'(q.num_raw / {13'h0000, ratio});
        next_q.order_warn = (ratio != 3'h1) && (q.order > 3'h2);
        if (16'(q.n_raw / {13'h0000, ratio}) < nmin) begin
          next_q.n_low = 1'b1;
          next_q.st    = PAC_IDLE;
        end else begin
          next_q.cnt = SETTLE_CYC;
          next_q.st  = PAC_ARM;
        end
      end
      PAC_ARM: begin
        next_q.mode = 1'b1;
        if (q.cnt == 8'h00 && q.mode) begin
          if (q.cat == `PAC_CAT3 || q.use_pin) begin
            next_q.pin = 1'b1;
            next_q.cnt = PULSE_CYC - 8'h01;  // Counting down to zero gives the full width.
            next_q.st  = PAC_PIN;
          end else if (q.cat == `PAC_CAT2) begin
            next_q.mode = 1'b0;
            next_q.cnt  = SETTLE_CYC;
            next_q.st   = PAC_DROP;
          end else begin
            next_q.aligned = 1'b1;
            next_q.st      = PAC_IDLE;
          end
        end
      end
      PAC_DROP: begin
        if (q.cnt == 8'h00) begin
          next_q.mode = 1'b1;
          next_q.cnt  = SETTLE_CYC;
          next_q.st   = PAC_RAISE;
        end
      end
      PAC_RAISE: begin
        if (q.cnt == 8'h00) begin
          next_q.aligned = 1'b1;
          next_q.st      = PAC_IDLE;
        end
      end
      PAC_PIN: begin
        if (q.cnt == 8'h00) begin
          next_q.pin     = 1'b0;
          next_q.aligned = 1'b1;
          next_q.st      = PAC_IDLE;
        end
      end
      default: begin
        next_q.st = PAC_IDLE;
      end
    endcase
    // Frame reference request: only once aligned in alignment mode.
    if (q.fcnt != 8'h00) begin
      next_q.fcnt = q.fcnt - 8'h01;
    end else if (q.repeat_mode) begin
      next_q.freq = 1'b0;
    end
    if (wr_acc && paddr == `PAC_CTRL_ADDR && pwdata[`PAC_CTRL_FRAME_STOP]) begin
      next_q.freq = 1'b0;
      next_q.fcnt = 8'h00;
    end else if (wr_acc && paddr == `PAC_CTRL_ADDR && pwdata[`PAC_CTRL_FRAME_GO]) begin
      if (q.aligned && q.mode && q.st == PAC_IDLE) begin
        next_q.freq      = 1'b1;
        next_q.fcnt      = pwdata[`PAC_CTRL_REPEAT] ? (PULSE_CYC - 8'h01) : 8'h00;
        next_q.frame_err = 1'b0;
      end else begin
        next_q.frame_err = 1'b1;
      end
    end
    // Read data is captured in the setup cycle for the access cycle.
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `PAC_CTRL_ADDR:   next_q.prdata = {5'h00, q.sdiv, 1'b0, q.pre, 1'b0,
                                           q.bpc, q.pulsed, q.repeat_mode, q.cat,
                                           q.use_pin, 3'h0};
        `PAC_MUX_ADDR:    next_q.prdata = {21'h000000, q.order, q.div2, q.divider_second_stage, q.out_b,
                                           q.out_a};
        `PAC_FEED_ADDR:   next_q.prdata = {q.num_raw, q.n_raw};
        `PAC_DELAY_ADDR:  next_q.prdata = {24'h000000, q.dword};
        `PAC_STATUS_ADDR: next_q.prdata = {19'h0_0000, q.st, ratio, q.frame_err,
                                           q.order_warn, q.n_low, q.ref_cat4, q.freq,
                                           q.aligned, (q.st != PAC_IDLE)};
        default:          next_q.prdata = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.st    <= PAC_IDLE;
      q.bpc   <= `PAC_BPC_RST;
      q.n_raw <= `PAC_N_RST;
      q.n_out <= `PAC_N_RST;
      q.out_a <= `PAC_SEL_VCO;
      q.out_b <= `PAC_SEL_VCO;
      q.dword <= `PAC_DWORD_RST;
    end else begin
      q <= next_q;
    end
  end

  // The pin changes half a period after the reference edge, clear of it.
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= q.pin;
    end
  end

  // Outputs towards the synthesizer, from flip-flops except the decoded pin ignore, frame enable and delay weights.
  always_comb begin
    prdata                       = q.prdata;
    phase_align_pin              = pin_q;
    frame_ref_request            = q.freq;
    dev_cfg.phase_align_mode     = q.mode;
    dev_cfg.sync_pin_ignore      = !(q.mode && (q.use_pin || q.cat == `PAC_CAT3));
    dev_cfg.frame_ref_enable     = (q.out_b == `PAC_SEL_FRAME);
    dev_cfg.frame_ref_repeat     = q.repeat_mode;
    dev_cfg.frame_ref_pulsed     = q.pulsed;
    dev_cfg.burst_pulse_count    = q.bpc;
    dev_cfg.frame_ref_predivider = q.pre;
    dev_cfg.frame_ref_divider    = q.sdiv;
    dev_cfg.out_a_select         = q.out_a;
    dev_cfg.out_b_select         = q.out_b;
    dev_cfg.feedback_int_divider = q.n_out;
    dev_cfg.frac_numerator       = q.num_out;
    dev_cfg.modulator_order      = q.order;
    dev_cfg.modulator_seed       = q.seed;
    dev_cfg.seed_load            = q.seed_ld;
    {dev_cfg.delay_weight_1, dev_cfg.delay_weight_2,
     dev_cfg.delay_weight_3, dev_cfg.delay_weight_4} = wts;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  weight_sum_a: assert property (9'(wts[23:18]) + 9'(wts[17:12]) + 9'(wts[11:6]) +
                                 9'(wts[5:0]) == `PAC_WSUM)
    else $error("delay weights do not sum to 63");
  frame_enable_a: assert property (dev_cfg.frame_ref_enable == (q.out_b == `PAC_SEL_FRAME))
    else $error("frame enable disagrees with output B select");
  pin_ignore_a: assert property (!dev_cfg.phase_align_mode |-> dev_cfg.sync_pin_ignore)
    else $error("pin not ignored outside alignment mode");
  cat4_refuse_a: assert property (q.st == PAC_IDLE && wr_acc && paddr == `PAC_CTRL_ADDR &&
                                  pwdata[`PAC_CTRL_ALIGN_GO] &&
                                  pwdata[`PAC_CTRL_CAT_LSB +: 2] == `PAC_CAT4
                                  |=> q.st == PAC_IDLE && q.ref_cat4 && !$rose(q.mode))
    else $error("category four alignment was attempted");
  frame_gate_a: assert property ($rose(frame_ref_request) |-> q.mode && q.aligned)
    else $error("frame request raised outside alignment mode");
  n_floor_a: assert property ($rose(q.mode) |-> q.n_out >= nmin)
    else $error("feedback divider below modulator floor");
  n_scaled_a: assert property ($rose(q.mode) |-> q.n_out == 16'(q.n_raw / {13'h0000, ratio}))
    else $error("feedback divider not scaled by included ratio");
  toggle_seq_a: assert property (q.st == PAC_DROP && q.cnt == 8'h00 |=> q.mode ##1 q.mode)
    else $error("mode toggle did not return to one");
  pin_pulse_a: assert property ($rose(q.pin) |-> q.mode [*5])
    else $error("pin pulsed outside alignment mode");
  pin_half_a: assert property ($rose(q.pin) |=> phase_align_pin)
    else $error("pin not retimed within one period");

  sw_align_c: cover property (q.st == PAC_DROP ##[1:100] q.st == PAC_IDLE && q.aligned);
  pin_align_c: cover property (q.st == PAC_PIN ##[1:20] q.aligned);
  frame_go_c: cover property ($rose(frame_ref_request));

endmodule

`default_nettype wire

// ---- hdl/pac_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  phase alignment and frame reference controller.
  Assumes a 12-bit APB byte address and a 40 MHz pclk.
*/
`ifndef PAC_REGS_SVH
`define PAC_REGS_SVH

// Register byte addresses on the APB side.
`define PAC_CTRL_ADDR    12'h000
`define PAC_MUX_ADDR     12'h004
`define PAC_FEED_ADDR    12'h008
`define PAC_DELAY_ADDR   12'h00C
`define PAC_STATUS_ADDR  12'h010
`define PAC_SEED_ADDR    12'h014

// Control register fields.
`define PAC_CTRL_ALIGN_GO   0
`define PAC_CTRL_FRAME_GO   1
`define PAC_CTRL_FRAME_STOP 2
`define PAC_CTRL_USE_PIN    3
`define PAC_CTRL_CAT_LSB    4
`define PAC_CTRL_REPEAT     6
`define PAC_CTRL_PULSED     7
`define PAC_CTRL_BPC_LSB    8
`define PAC_CTRL_PRE_LSB    13
`define PAC_CTRL_SDIV_LSB   16

// Output selection and modulator fields.
`define PAC_MUX_A_LSB     0
`define PAC_MUX_B_LSB     2
`define PAC_MUX_DIVIDER_SECOND_STAGE_LSB  4
`define PAC_MUX_DIV2      7
`define PAC_MUX_ORDER_LSB 8

// Output select codes.
`define PAC_SEL_OUTPUT_DIVIDER_RATIO  2'h0
`define PAC_SEL_VCO    2'h1
`define PAC_SEL_FRAME  2'h2

// Category codes; category four marks a setup in which alignment is impossible.
`define PAC_CAT4       2'h3
`define PAC_CAT3       2'h2
`define PAC_CAT2       2'h1

// Reset values.
`define PAC_BPC_RST    4'h4
`define PAC_N_RST      16'h0064
`define PAC_DWORD_RST  8'h00

// Feedback divider floors for modulator orders two and three, delay word limit and weight sum.
`define PAC_NMIN_O2    16'h002D
`define PAC_NMIN_O3    16'h0031
`define PAC_DWORD_MAX  8'hF7
`define PAC_WSUM       9'h03F

// Timing: least times, rounded up to whole pclk cycles.
`define PAC_CLK_NS         25
`define PAC_PIN_PULSE_NS   100
`define PAC_SETTLE_NS      1000
`define PAC_PIN_PULSE_CYC  ((`PAC_PIN_PULSE_NS + `PAC_CLK_NS - 1) / `PAC_CLK_NS)
`define PAC_SETTLE_CYC     ((`PAC_SETTLE_NS + `PAC_CLK_NS - 1) / `PAC_CLK_NS)

`endif

// ---- hdl/pac_pkg.sv ----
/*
  Types of the phase alignment and frame reference controller.
  Assumes the constants of pac_regs.svh.
*/
package pac_pkg;

  // Alignment sequencer states.
  typedef enum logic [2:0] {
    PAC_IDLE  = 3'b000,
    PAC_PROG  = 3'b001,
    PAC_ARM   = 3'b010,
    PAC_DROP  = 3'b011,
    PAC_RAISE = 3'b100,
    PAC_PIN   = 3'b101
  } pac_state_t;

  // Settings driven towards the synthesizer.
  typedef struct packed {
    logic        phase_align_mode;
    logic        sync_pin_ignore;
    logic        frame_ref_enable;
    logic        frame_ref_repeat;
    logic        frame_ref_pulsed;
    logic [3:0]  burst_pulse_count;
    logic [1:0]  frame_ref_predivider;
    logic [10:0] frame_ref_divider;
    logic [1:0]  out_a_select;
    logic [1:0]  out_b_select;
    logic [15:0] feedback_int_divider;
    logic [15:0] frac_numerator;
    logic [2:0]  modulator_order;
    logic [15:0] modulator_seed;   // Phase step word added on each load.
    logic        seed_load;        // One-cycle strobe: apply the seed step.
    logic [5:0]  delay_weight_1;
    logic [5:0]  delay_weight_2;
    logic [5:0]  delay_weight_3;
    logic [5:0]  delay_weight_4;
  } pac_dev_cfg_t;

  // Whole state of the controller except pin_q.
  typedef struct packed {
    pac_state_t  st;
    logic [7:0]  cnt;
    logic        use_pin;
    logic [1:0]  cat;
    logic        repeat_mode;
    logic        pulsed;
    logic [3:0]  bpc;
    logic [1:0]  pre;
    logic [10:0] sdiv;
    logic [1:0]  out_a;
    logic [1:0]  out_b;
    logic [2:0]  divider_second_stage;
    logic        div2;
    logic [2:0]  order;
    logic [15:0] n_raw;
    logic [15:0] num_raw;
    logic [7:0]  dword;
    logic [15:0] seed;
    logic        seed_ld;
    logic [15:0] n_out;
    logic [15:0] num_out;
    logic        mode;
    logic        pin;
    logic        freq;
    logic [7:0]  fcnt;
    logic        aligned;
    logic        ref_cat4;
    logic        n_low;
    logic        order_warn;
    logic        frame_err;
    logic [31:0] prdata;
  } pac_st_t;

endpackage

// ---- testbench/pac_dev_model.sv ----
/*
  Synthesizer model: counts alignment events, pin pulses and frame pulses.
  Assumes the reference and interpolator clocks both run at pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pac_dev_model
  import pac_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire pac_dev_cfg_t cfg,
  input  wire logic         pin,
  input  wire logic         req,
  output logic [7:0]        mode_ev,
  output logic [7:0]        pin_ev,
  output logic [7:0]        pin_w,
  output logic [7:0]        req_w,
  output logic [7:0]        pulses,
  output logic              pin_bad,
  output logic [15:0]       seed_ph
);
  logic        mode_q, pin_s, pin_q, req_q; // Retimed copies.
  logic [7:0]  pw, rw;                       // Running pulse widths.
  logic [15:0] dcnt;                         // Pulse divider count.

  // A pin edge while the reference clock is high is flagged.
  initial pin_bad = 1'b0;
  always @(pin) if (pclk === 1'b1) pin_bad = 1'b1;

  // Retiming, event counting and frame pulse generation.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode_q, pin_s, pin_q, req_q} <= 4'h0;
      {mode_ev, pin_ev, pin_w, req_w, pulses, pw, rw} <= 56'h0;
      dcnt <= 16'h0000;
      seed_ph <= 16'h0000;
    end else begin
      mode_q <= cfg.phase_align_mode;
      pin_s  <= pin; // Pin taken at the next reference edge.
      pin_q  <= pin_s;
      req_q  <= req;
      if (cfg.phase_align_mode && !mode_q) mode_ev <= mode_ev + 8'h01;
      if (pin_s && !pin_q && cfg.phase_align_mode) pin_ev <= pin_ev + 8'h01;
      // Any alignment event restarts the seed phase; seed loads then accumulate while the modulator order is nonzero.
      if ((cfg.phase_align_mode && !mode_q) || (pin_s && !pin_q && cfg.phase_align_mode)) begin
        seed_ph <= 16'h0000;
      end else if (cfg.seed_load && cfg.modulator_order != 3'h0) begin
        seed_ph <= seed_ph + cfg.modulator_seed;
      end
      pw <= pin_s ? pw + 8'h01 : 8'h00;
      if (!pin_s && pin_q) pin_w <= pw;
      rw <= req ? rw + 8'h01 : 8'h00;
      if (!req && req_q) req_w <= rw; // Both request edges retimed.
      if (req && !req_q) begin
        pulses <= 8'h00;
        dcnt   <= 16'h0000;
      end else if (req && cfg.frame_ref_enable && !cfg.frame_ref_repeat) begin
        // Period is twice the divider ratio of 4 plus twice the code.
        if (dcnt == 16'h0007 + {3'h0, cfg.frame_ref_divider, 2'h0}) begin
          dcnt <= 16'h0000;
          if (!cfg.frame_ref_pulsed || pulses < {4'h0, cfg.burst_pulse_count}) begin
            pulses <= pulses + 8'h01;
          end
        end else begin
          dcnt <= dcnt + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_phase_align_and_frame_ref_ctrl.sv ----
/*
  Self-checking bench of the alignment and frame reference controller.
  Assumes pac_ctrl, pac_pkg and the device model are compiled first.
*/
`include "pac_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_phase_align_and_frame_ref_ctrl
  import pac_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdat, obs;
  pac_dev_cfg_t dev_cfg;
  logic         align_pin, frame_ref_request, chk_rd, pin_bad;
  logic [7:0]   mode_ev, pin_ev, pin_w, req_w, pulses, dv;
  logic [15:0]  seed_ph;     // Accumulated seed phase seen by the model.
  logic [65:0]  q[$];        // Expected {mask, value} notes.
  int           fails, tests_run, cyc;
  event         obs_ev;
  logic [10:0]  mux_tab[4] = '{11'h035, 11'h034, 11'h029, 11'h0A1};
  logic [7:0]   dly_tab[7] = '{8'h00, 8'h24, 8'h63, 8'hA2, 8'hE1, 8'hF7, 8'hFF};
  logic [19:0]  nf_tab[4] = '{20'hA_002C, 20'h2_002D, 20'hB_0030, 20'h3_0031};
  logic [4:0]   al_tab[3] = '{5'h11, 5'h0D, 5'h0A};

  pac_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_cfg(dev_cfg), .phase_align_pin(align_pin),
    .frame_ref_request(frame_ref_request));
  pac_dev_model dev (.pclk(pclk), .presetn(presetn), .cfg(dev_cfg), .pin(align_pin),
    .req(frame_ref_request), .mode_ev(mode_ev), .pin_ev(pin_ev), .pin_w(pin_w),
    .req_w(req_w), .pulses(pulses), .pin_bad(pin_bad), .seed_ph(seed_ph));

  // The clock runs at 40 MHz.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // The run is cut short if it hangs.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // Prints the counts and the verdict.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Takes the oldest note and compares it with a result.
  task automatic cmp(input logic [32:0] got);
    logic [65:0] n;
    n = q.pop_front();
    tests_run++;
    if ((got & n[65:33]) !== n[32:0]) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got & n[65:33], n[32:0]);
    end
  endtask

  // Results appear as bus reads or as sampled device values.
  always @(obs_ev) cmp({1'b0, obs});
  always @(posedge pclk) if (psel && penable && pready && !pwrite && chk_rd) cmp({pslverr, prdata});

  // One APB transfer; waits for pready in the access phase.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; chk_rd <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0; penable <= 1'b0; chk_rd <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    q.push_back({m, e});
    apb(1'b0, a, 32'h0000_0000, 1'b1);
  endtask

  // Notes an expected device value and hands the observed one over.
  task automatic see(input logic [31:0] v, input logic [31:0] e);
    q.push_back({1'b0, 32'hFFFF_FFFF, 1'b0, e});
    obs = v;
    -> obs_ev;
    #1;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Starts an alignment and polls busy until it clears.
  task automatic align(input logic [1:0] c, input logic p);
    wr(`PAC_CTRL_ADDR, {26'h0, c, p, 3'h1});
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, `PAC_STATUS_ADDR, 32'h0000_0000, 1'b0);
      if (rdat[0] === 1'b0) break;
    end
  endtask

  // Included ratio expected from a MUX register value.
  function automatic logic [2:0] xratio(input logic [10:0] m);
    if (m[1:0] != 2'h0 && m[3:2] != 2'h0 && m[3:2] != 2'h2) return 3'h1;
    return m[7] ? 3'h4 : {m[5:4], 1'b0};
  endfunction

  // Delay weights {1,2,3,4} expected for a delay word.
  function automatic logic [23:0] xw(input logic [7:0] v);
    logic [5:0] k;
    if (v > 8'hF7) v = 8'hF7;
    if (v < 8'h24) begin
      k = v[5:0];
      return {6'h24 - k, 6'h1B + k, 12'h000};
    end
    if (v < 8'h63) begin
      k = 6'(v - 8'h24);
      return {6'h00, 6'h3F - k, k, 6'h00};
    end
    if (v < 8'hA2) begin
      k = 6'(v - 8'h63);
      return {12'h000, 6'h3F - k, k};
    end
    if (v < 8'hE1) begin
      k = 6'(v - 8'hA2);
      return {k, 12'h000, 6'h3F - k};
    end
    k = 6'(v - 8'hE1);
    return {6'h3F - k, k, 12'h000};
  endfunction

  // Main sequence.
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; chk_rd = 0; presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(37));
    @(posedge pclk);
    see(32'(dev_cfg.sync_pin_ignore), 32'h0000_0001);
    see(32'(dev_cfg.burst_pulse_count), 32'h0000_0004);
    rd(12'h020, {1'b1, 32'h0000_0000}, {33{1'b1}}); // Unmapped address is refused.
    foreach (mux_tab[i]) begin
      wr(`PAC_MUX_ADDR, 32'(mux_tab[i]));
      rd(`PAC_STATUS_ADDR, 33'(xratio(mux_tab[i])) << 7, 33'h0_0000_0380);
      see(32'(dev_cfg.frame_ref_enable), 32'(mux_tab[i][3:2] == 2'h2));
      see(32'({dev_cfg.out_b_select, dev_cfg.out_a_select}), 32'(mux_tab[i][3:0]));
    end
    for (int i = 0; i < 10; i++) begin
      dv = (i < 7) ? dly_tab[i] : 8'($urandom % 248);
      wr(`PAC_DELAY_ADDR, 32'(dv));
      rd(`PAC_DELAY_ADDR, 33'(dv), 33'h0_0000_00FF);
      see(32'({dev_cfg.delay_weight_1, dev_cfg.delay_weight_2, dev_cfg.delay_weight_3,
               dev_cfg.delay_weight_4}), 32'(xw(dv)));
      see(32'(dev_cfg.delay_weight_1) + 32'(dev_cfg.delay_weight_2) + 32'(dev_cfg.delay_weight_3)
          + 32'(dev_cfg.delay_weight_4), 32'h0000_003F);
    end
    wr(`PAC_CTRL_ADDR, 32'h05A5_4990);
    rd(`PAC_CTRL_ADDR, 33'h0_05A5_4990, {33{1'b1}});
    see(32'({dev_cfg.frame_ref_divider, dev_cfg.frame_ref_predivider, dev_cfg.burst_pulse_count}),
        32'h0001_6969);
    wr(`PAC_CTRL_ADDR, 32'h0000_0002);
    rd(`PAC_STATUS_ADDR, 33'h0_0000_0040, 33'h0_0000_0040);
    see(32'(frame_ref_request), 32'h0000_0000);
    foreach (nf_tab[i]) begin
      wr(`PAC_MUX_ADDR, {21'h0, nf_tab[i][18:16], 8'h05});
      wr(`PAC_FEED_ADDR, {16'h0000, nf_tab[i][15:0]});
      align(2'h0, 1'b0);
      rd(`PAC_STATUS_ADDR, 33'(nf_tab[i][19]) << 4, 33'h0_0000_0010);
    end
    do_reset();
    align(2'h3, 1'b0);
    rd(`PAC_STATUS_ADDR, 33'h0_0000_0008, 33'h0_0000_000B);
    see(32'(dev_cfg.phase_align_mode), 32'h0000_0000);
    do_reset();
    wr(`PAC_MUX_ADDR, 32'h0000_0329);
    wr(`PAC_FEED_ADDR, 32'h0190_00C8);
    align(2'h0, 1'b0);
    see(32'(dev_cfg.feedback_int_divider), 32'h0000_0032);
    see(32'(dev_cfg.frac_numerator), 32'h0000_0064);
    see(32'(mode_ev), 32'h0000_0001);
    rd(`PAC_STATUS_ADDR, 33'h0_0000_0022, 33'h0_0000_0023);
    wr(`PAC_SEED_ADDR, 32'h0000_0005);
    wr(`PAC_SEED_ADDR, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    see(32'(seed_ph), 32'h0000_000C);
    align(2'h0, 1'b0);
    see(32'(seed_ph), 32'h0000_0000);
    wr(`PAC_CTRL_ADDR, 32'h0000_0382);
    repeat (60) @(posedge pclk);
    see(32'(pulses), 32'h0000_0003);
    see(32'(frame_ref_request), 32'h0000_0001);
    wr(`PAC_CTRL_ADDR, 32'h0000_0004);
    @(posedge pclk);
    see(32'(frame_ref_request), 32'h0000_0000);
    wr(`PAC_CTRL_ADDR, 32'h0000_0042);
    repeat (8) @(posedge pclk);
    see(32'(req_w), 32'h0000_0004);
    foreach (al_tab[i]) begin
      do_reset();
      align(al_tab[i][1:0], al_tab[i][2]);
      repeat (8) @(posedge pclk);
      see(32'(mode_ev), 32'(al_tab[i][4:3]));
      see(32'(pin_ev), 32'(al_tab[i][2] | al_tab[i][1]));
      see(32'(pin_w), (al_tab[i][2] | al_tab[i][1]) ? 32'h0000_0004 : 32'h0000_0000);
      see(32'(dev_cfg.sync_pin_ignore), 32'(!(al_tab[i][2] | al_tab[i][1])));
      see(32'(pin_bad), 32'h0000_0000);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
